// ---- common/sensor_cfg_pkg.sv ----
package sensor_cfg_pkg;
	// register addresses on the host port
	localparam logic [7:0] ADDR_SAMPLE_DIV   = 8'h19;
	localparam logic [7:0] ADDR_GYRO_LPF     = 8'h1A;
	localparam logic [7:0] ADDR_GYRO_CFG     = 8'h1B;
	localparam logic [7:0] ADDR_ACCEL_CFG    = 8'h1C;
	localparam logic [7:0] ADDR_ACCEL_CFG2   = 8'h1D;
	localparam logic [7:0] ADDR_LP_GYRO_CFG  = 8'h1E;
	// writable bits per register; everything else is reserved and reads zero
	localparam logic [7:0] MASK_GYRO_CFG     = 8'hFB;
	localparam logic [7:0] MASK_ACCEL_CFG    = 8'hF8;
	localparam logic [7:0] MASK_ACCEL_CFG2   = 8'h3F;
	localparam logic [7:0] MASK_LP_GYRO_CFG  = 8'hF0;
	localparam logic [7:0] MASK_GYRO_LPF     = 8'h07;
	// values after reset
	localparam logic [7:0] RST_CFG           = 8'h00;
	// field positions
	localparam int         POS_ST_X          = 7;
	localparam int         POS_ST_Y          = 6;
	localparam int         POS_ST_Z          = 5;
	localparam int         POS_RANGE_LSB     = 3;
	localparam int         POS_A_BYPASS      = 3;
	localparam int         POS_A_AVG_LSB     = 4;
	localparam int         POS_G_CYCLE       = 7;
	localparam int         POS_G_AVG_LSB     = 4;
	// internal timebase: 32 kHz tick from 10 MHz core clock
	localparam int         CLK_HZ            = 10_000_000;
	localparam int         BASE_HZ           = 32_000;
	localparam int         BASE_CYCLES       = CLK_HZ / BASE_HZ;
	// filter rates, counted in 32 kHz base ticks per output
	localparam logic [3:0] TICKS_32K         = 4'h1;
	localparam logic [3:0] TICKS_8K          = 4'h4;
	localparam logic [3:0] TICKS_4K          = 4'h8;
	localparam logic [5:0] TICKS_1K          = 6'h20;
	// accelerometer bandwidth codes, Hz times ten
	localparam logic [15:0] BW_A_BYPASS      = 16'h28DC;
	localparam logic [15:0] BW_A_218         = 16'h0885;
	localparam logic [15:0] BW_A_420         = 16'h1068;
	typedef enum logic [1:0] {
		RATE_32K = 2'b00,
		RATE_8K  = 2'b01,
		RATE_4K  = 2'b10,
		RATE_1K  = 2'b11
	} rate_t;
endpackage

// ---- rtl/rate_divider.sv ----
`timescale 1ns/1ps
// turns base ticks into filter ticks, then divides by 1 + divider
module rate_divider (
	input  wire logic                 core_clk,
	input  wire logic                 rstn,
	input  wire logic                 base_tick,
	input  wire sensor_cfg_pkg::rate_t rate,
	input  wire logic [7:0]           sample_rate_divider,
	output logic                      filter_tick,
	output logic                      sample_tick
);
	logic [5:0] pre_cnt;
	logic [5:0] next_pre_cnt;
	logic [7:0] div_cnt;
	logic [7:0] next_div_cnt;
	logic [5:0] pre_len;

	// ticks of 32 kHz per filter output
	always_comb begin
		case (rate)
			sensor_cfg_pkg::RATE_32K: pre_len = {2'h0, sensor_cfg_pkg::TICKS_32K};
			sensor_cfg_pkg::RATE_8K:  pre_len = {2'h0, sensor_cfg_pkg::TICKS_8K};
			sensor_cfg_pkg::RATE_4K:  pre_len = {2'h0, sensor_cfg_pkg::TICKS_4K};
			default:                  pre_len = sensor_cfg_pkg::TICKS_1K;
		endcase
	end

	assign filter_tick = base_tick && (pre_cnt >= pre_len - 6'h01);

	// counters; divider is read live so a new value applies to the period already running
	always_comb begin
		next_pre_cnt = pre_cnt;
		next_div_cnt = div_cnt;
		if (filter_tick) begin
			next_pre_cnt = 6'h00;
			next_div_cnt = (div_cnt >= sample_rate_divider) ? 8'h00 : div_cnt + 8'h01;
		end else if (base_tick) begin
			next_pre_cnt = pre_cnt + 6'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			pre_cnt <= 6'h00;
			div_cnt <= 8'h00;
		end else begin
			pre_cnt <= next_pre_cnt;
			div_cnt <= next_div_cnt;
		end
	end

	assign sample_tick = filter_tick && (div_cnt >= sample_rate_divider);
endmodule

// ---- rtl/lp_averager.sv ----
`timescale 1ns/1ps
// counts samples of one averaging window; done pulses when depth is reached
module lp_averager #(
	parameter int CNT_W = 8
) (
	input  wire logic             core_clk,
	input  wire logic             rstn,
	input  wire logic             enable,
	input  wire logic             sample,
	input  wire logic [CNT_W-1:0] depth,
	output logic                  done
);
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;

	assign done = enable && sample && (cnt >= depth - CNT_W'(1));

	// restarts whenever disabled so a new window starts clean
	always_comb begin
		next_cnt = cnt;
		if (!enable || done)
			next_cnt = '0;
		else if (sample)
			next_cnt = cnt + CNT_W'(1);
	end

	always_ff @(posedge core_clk) begin
		if (!rstn)
			cnt <= '0;
		else
			cnt <= next_cnt;
	end
endmodule

// ---- rtl/motion_sensor_filter_config.sv ----
`timescale 1ns/1ps
// Contract
// - gyro config at 0x1B; bits 7,6,5 start X,Y,Z gyro self-test
// - gyro range bits 4:3 select 250, 500, 1000, 2000 dps
// - gyro bypass bits 1:0 choose filter use or bypass
// - gyro rate 32 kHz on bypass x1/10; else 8 kHz settings 0,7, 1 kHz
// - accel config at 0x1C; bits 7,6,5 start X,Y,Z accel self-test
// - accel range bits 4:3 select 2, 4, 8, 16 g
// - low-power accel averaging bits 5:4 pick 4, 8, 16, 32 samples
// - accel bypass bit 3 gives 4 kHz, 1046 Hz, no averaging
// - accel setting bits 2:0 pick bandwidth; 0,1 give 218.1, 7 gives 420 Hz
// - output rate is filter rate divided by one plus divider
// - accel low-power mode duty-cycles the accelerometer
// - 0x1E bit 7 enables low-power gyro, default 0
// - gyro averaging bits 6:4 pick 1x up to 128x, default 000
// - low-power gyro ignores the gyro lowpass setting
module motion_sensor_filter_config (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	input  wire logic        accel_lp_mode,
	output logic      [2:0]  gyro_selftest,
	output logic      [2:0]  accel_selftest,
	output logic      [1:0]  gyro_range_select,
	output logic      [1:0]  accel_range_select,
	output logic             gyro_filter_on,
	output logic      [3:0]  gyro_rate_khz,
	output logic      [15:0] accel_bw_x10,
	output logic      [2:0]  accel_rate_khz,
	output logic      [7:0]  accel_avg_count,
	output logic      [7:0]  gyro_avg_count,
	output logic             accel_sensor_on,
	output logic             gyro_sample_tick,
	output logic             accel_sample_tick
);
	logic [7:0] gyro_range_filter_cfg;
	logic [7:0] accel_range_cfg;
	logic [7:0] accel_filter_avg_cfg;
	logic [7:0] low_power_gyro_cfg;
	logic [7:0] sample_rate_divider;
	logic [7:0] gyro_lowpass_reg;
	logic [7:0] next_gyro_cfg;
	logic [7:0] next_accel_cfg;
	logic [7:0] next_accel_cfg2;
	logic [7:0] next_lp_cfg;
	logic [7:0] next_div;
	logic [7:0] next_glpf;
	// shadow copies that the datapath actually uses
	logic [7:0] act_gyro_cfg;
	logic [7:0] act_accel_cfg2;
	logic [7:0] act_lp_cfg;
	logic [7:0] act_glpf;
	logic [7:0] next_act_gyro_cfg;
	logic [7:0] next_act_accel_cfg2;
	logic [7:0] next_act_lp_cfg;
	logic [7:0] next_act_glpf;
	logic [8:0] base_cnt;
	logic [8:0] next_base_cnt;
	logic       base_tick;
	sensor_cfg_pkg::rate_t gyro_rate;
	sensor_cfg_pkg::rate_t accel_rate;
	logic       gyro_filter_tick;
	logic       accel_filter_tick;
	logic       gyro_div_tick;
	logic       accel_div_tick;
	logic       gyro_lp;
	logic       accel_lp;
	logic       gyro_avg_done;
	logic       accel_avg_done;
	logic       accel_on;
	logic       next_accel_on;

	// masked write: reserved bits never store
	function automatic logic [7:0] masked_write(input logic [7:0] old_v,
		input logic [7:0] addr, input logic [7:0] here, input logic [7:0] mask);
		masked_write = (reg_wr && addr == here) ? (reg_wdata & mask) : old_v;
	endfunction

	// 2^(code) as an averaging count
	function automatic logic [7:0] pow2(input logic [2:0] code);
		pow2 = 8'h01 << code;
	endfunction

	// host register writes
	always_comb begin
		next_gyro_cfg   = masked_write(gyro_range_filter_cfg, reg_addr,
			sensor_cfg_pkg::ADDR_GYRO_CFG, sensor_cfg_pkg::MASK_GYRO_CFG);
		next_accel_cfg  = masked_write(accel_range_cfg, reg_addr,
			sensor_cfg_pkg::ADDR_ACCEL_CFG, sensor_cfg_pkg::MASK_ACCEL_CFG);
		next_accel_cfg2 = masked_write(accel_filter_avg_cfg, reg_addr,
			sensor_cfg_pkg::ADDR_ACCEL_CFG2, sensor_cfg_pkg::MASK_ACCEL_CFG2);
		next_lp_cfg     = masked_write(low_power_gyro_cfg, reg_addr,
			sensor_cfg_pkg::ADDR_LP_GYRO_CFG, sensor_cfg_pkg::MASK_LP_GYRO_CFG);
		next_div        = masked_write(sample_rate_divider, reg_addr,
			sensor_cfg_pkg::ADDR_SAMPLE_DIV, 8'hFF);
		next_glpf       = masked_write(gyro_lowpass_reg, reg_addr,
			sensor_cfg_pkg::ADDR_GYRO_LPF, sensor_cfg_pkg::MASK_GYRO_LPF);
	end

	// shadows load on any gyro or accel sample pulse, so a gyro period can take new settings at an accel boundary
	always_comb begin
		next_act_gyro_cfg   = act_gyro_cfg;
		next_act_accel_cfg2 = act_accel_cfg2;
		next_act_lp_cfg     = act_lp_cfg;
		next_act_glpf       = act_glpf;
		if (gyro_sample_tick || accel_sample_tick) begin
			next_act_gyro_cfg   = gyro_range_filter_cfg;
			next_act_accel_cfg2 = accel_filter_avg_cfg;
			next_act_lp_cfg     = low_power_gyro_cfg;
			next_act_glpf       = gyro_lowpass_reg;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			gyro_range_filter_cfg <= sensor_cfg_pkg::RST_CFG;
			accel_range_cfg       <= sensor_cfg_pkg::RST_CFG;
			accel_filter_avg_cfg  <= sensor_cfg_pkg::RST_CFG;
			low_power_gyro_cfg    <= sensor_cfg_pkg::RST_CFG;
			sample_rate_divider   <= sensor_cfg_pkg::RST_CFG;
			gyro_lowpass_reg      <= sensor_cfg_pkg::RST_CFG;
			act_gyro_cfg          <= sensor_cfg_pkg::RST_CFG;
			act_accel_cfg2        <= sensor_cfg_pkg::RST_CFG;
			act_lp_cfg            <= sensor_cfg_pkg::RST_CFG;
			act_glpf              <= sensor_cfg_pkg::RST_CFG;
		end else begin
			gyro_range_filter_cfg <= next_gyro_cfg;
			accel_range_cfg       <= next_accel_cfg;
			accel_filter_avg_cfg  <= next_accel_cfg2;
			low_power_gyro_cfg    <= next_lp_cfg;
			sample_rate_divider   <= next_div;
			gyro_lowpass_reg      <= next_glpf;
			act_gyro_cfg          <= next_act_gyro_cfg;
			act_accel_cfg2        <= next_act_accel_cfg2;
			act_lp_cfg            <= next_act_lp_cfg;
			act_glpf              <= next_act_glpf;
		end
	end

	// read mux; reserved bits are already zero in storage
	always_comb begin
		case (reg_addr)
			sensor_cfg_pkg::ADDR_GYRO_CFG:    reg_rdata = gyro_range_filter_cfg;
			sensor_cfg_pkg::ADDR_ACCEL_CFG:   reg_rdata = accel_range_cfg;
			sensor_cfg_pkg::ADDR_ACCEL_CFG2:  reg_rdata = accel_filter_avg_cfg;
			sensor_cfg_pkg::ADDR_LP_GYRO_CFG: reg_rdata = low_power_gyro_cfg;
			sensor_cfg_pkg::ADDR_SAMPLE_DIV:  reg_rdata = sample_rate_divider;
			sensor_cfg_pkg::ADDR_GYRO_LPF:    reg_rdata = gyro_lowpass_reg;
			default:                          reg_rdata = 8'h00;
		endcase
	end

	// self-test and accel range go straight out, the front end latches them; gyro range comes from the shadow
	assign gyro_selftest      = gyro_range_filter_cfg[sensor_cfg_pkg::POS_ST_X -: 3];
	assign accel_selftest     = accel_range_cfg[sensor_cfg_pkg::POS_ST_X -: 3];
	assign gyro_range_select  = act_gyro_cfg[sensor_cfg_pkg::POS_RANGE_LSB +: 2];
	assign accel_range_select = accel_range_cfg[sensor_cfg_pkg::POS_RANGE_LSB +: 2];

	// 32 kHz base tick from the core clock
	always_comb begin
		next_base_cnt = (base_cnt == 9'(sensor_cfg_pkg::BASE_CYCLES - 1)) ? 9'h000
			: base_cnt + 9'h001;
	end
	assign base_tick = (base_cnt == 9'(sensor_cfg_pkg::BASE_CYCLES - 1));

	always_ff @(posedge core_clk) begin
		if (!rstn)
			base_cnt <= 9'h000;
		else
			base_cnt <= next_base_cnt;
	end

	assign gyro_lp  = act_lp_cfg[sensor_cfg_pkg::POS_G_CYCLE];
	assign accel_lp = accel_lp_mode && !act_accel_cfg2[sensor_cfg_pkg::POS_A_BYPASS];

	// gyro filter rate; low-power mode uses the 1 kHz averager instead
	always_comb begin
		gyro_filter_on = 1'b0;
		if (gyro_lp)
			gyro_rate = sensor_cfg_pkg::RATE_1K;
		else if (act_gyro_cfg[0] || act_gyro_cfg[1:0] == 2'b10)
			gyro_rate = sensor_cfg_pkg::RATE_32K;
		else begin
			gyro_filter_on = 1'b1;
			if (act_glpf[2:0] == 3'h0 || act_glpf[2:0] == 3'h7)
				gyro_rate = sensor_cfg_pkg::RATE_8K;
			else
				gyro_rate = sensor_cfg_pkg::RATE_1K;
		end
		if (gyro_lp)
			gyro_filter_on = 1'b1;
	end

	always_comb begin
		case (gyro_rate)
			sensor_cfg_pkg::RATE_32K: gyro_rate_khz = 4'h0 + 4'(32 % 16) + 4'h0;
			sensor_cfg_pkg::RATE_8K:  gyro_rate_khz = 4'h8;
			default:                  gyro_rate_khz = 4'h1;
		endcase
	end

	// accel bandwidth and rate
	always_comb begin
		accel_rate = sensor_cfg_pkg::RATE_1K;
		if (act_accel_cfg2[sensor_cfg_pkg::POS_A_BYPASS]) begin
			accel_rate   = sensor_cfg_pkg::RATE_4K;
			accel_bw_x10 = sensor_cfg_pkg::BW_A_BYPASS;
		end else begin
			case (act_accel_cfg2[2:0])
				3'h0, 3'h1: accel_bw_x10 = sensor_cfg_pkg::BW_A_218;
				3'h2:       accel_bw_x10 = 16'h03DE;
				3'h3:       accel_bw_x10 = 16'h01C0;
				3'h4:       accel_bw_x10 = 16'h00D4;
				3'h5:       accel_bw_x10 = 16'h0066;
				3'h6:       accel_bw_x10 = 16'h0033;
				default:    accel_bw_x10 = sensor_cfg_pkg::BW_A_420;
			endcase
		end
	end
	assign accel_rate_khz = (accel_rate == sensor_cfg_pkg::RATE_4K) ? 3'h4 : 3'h1;

	// averaging depths; accel bypass means one sample
	assign accel_avg_count = accel_lp ? (8'h04 << act_accel_cfg2[sensor_cfg_pkg::POS_A_AVG_LSB +: 2])
		: 8'h01;
	assign gyro_avg_count  = gyro_lp ? pow2(act_lp_cfg[sensor_cfg_pkg::POS_G_AVG_LSB +: 3])
		: 8'h01;

	rate_divider u_gyro_div (
		.core_clk            (core_clk),
		.rstn                (rstn),
		.base_tick           (base_tick),
		.rate                (gyro_rate),
		.sample_rate_divider (sample_rate_divider),
		.filter_tick         (gyro_filter_tick),
		.sample_tick         (gyro_div_tick)
	);

	rate_divider u_accel_div (
		.core_clk            (core_clk),
		.rstn                (rstn),
		.base_tick           (base_tick),
		.rate                (accel_rate),
		.sample_rate_divider (sample_rate_divider),
		.filter_tick         (accel_filter_tick),
		.sample_tick         (accel_div_tick)
	);

	lp_averager #(.CNT_W(8)) u_gyro_avg (
		.core_clk (core_clk),
		.rstn     (rstn),
		.enable   (gyro_lp),
		.sample   (gyro_filter_tick),
		.depth    (gyro_avg_count),
		.done     (gyro_avg_done)
	);

	lp_averager #(.CNT_W(8)) u_accel_avg (
		.core_clk (core_clk),
		.rstn     (rstn),
		.enable   (accel_lp && accel_on),
		.sample   (accel_filter_tick),
		.depth    (accel_avg_count),
		.done     (accel_avg_done)
	);

	// accel duty cycle: powered from period start until its window is averaged
	always_comb begin
		next_accel_on = accel_on;
		if (!accel_lp)
			next_accel_on = 1'b1;
		else if (accel_div_tick)
			next_accel_on = 1'b1;
		else if (accel_avg_done)
			next_accel_on = 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (!rstn)
			accel_on <= 1'b1;
		else
			accel_on <= next_accel_on;
	end

	assign accel_sensor_on   = accel_on;
	assign gyro_sample_tick  = gyro_div_tick;
	assign accel_sample_tick = accel_div_tick;

	// gyro is only in low power once the host set the enable; on host
	gyro_lp_follows_a: assert property (@(posedge core_clk) disable iff (!rstn)
		gyro_lp |-> gyro_rate == sensor_cfg_pkg::RATE_1K) else $error("lp gyro rate");
	gyro_bypass_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(!gyro_lp && act_gyro_cfg[0]) |-> gyro_rate_khz == 4'h0)
		else $error("gyro bypass rate");
	accel_bypass_a: assert property (@(posedge core_clk) disable iff (!rstn)
		act_accel_cfg2[3] |-> accel_rate_khz == 3'h4 && accel_avg_count == 8'h01)
		else $error("accel bypass");
	reserved_zero_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(reg_rd && reg_addr == sensor_cfg_pkg::ADDR_ACCEL_CFG) |-> reg_rdata[2:0] == 3'h0)
		else $error("reserved bits");
	write_store_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(reg_wr && reg_addr == sensor_cfg_pkg::ADDR_GYRO_CFG) |=>
		gyro_selftest == $past(reg_wdata[7:5])) else $error("gyro st write");
	lp_enable_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(reg_wr && reg_addr == sensor_cfg_pkg::ADDR_LP_GYRO_CFG) |=>
		low_power_gyro_cfg[7] == $past(reg_wdata[7])) else $error("lp enable");
	shadow_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!(gyro_sample_tick || accel_sample_tick) |=> $stable(act_gyro_cfg))
		else $error("mid period change");
	accel_avg_a: assert property (@(posedge core_clk) disable iff (!rstn)
		accel_lp |-> accel_avg_count == (8'h04 << act_accel_cfg2[5:4]))
		else $error("accel avg");
	duty_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(accel_lp && accel_avg_done && !accel_div_tick) |=> !accel_on || !accel_lp)
		else $error("duty cycle");
endmodule

// ---- tb/motion_sensor_filter_config_bench.sv ----
`timescale 1ns/1ps
module motion_sensor_filter_config_bench;
	logic        core_clk;
	logic        rstn;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic        accel_lp_mode;
	logic [2:0]  gyro_selftest;
	logic [2:0]  accel_selftest;
	logic [1:0]  gyro_range_select;
	logic [1:0]  accel_range_select;
	logic        gyro_filter_on;
	logic [3:0]  gyro_rate_khz;
	logic [15:0] accel_bw_x10;
	logic [2:0]  accel_rate_khz;
	logic [7:0]  accel_avg_count;
	logic [7:0]  gyro_avg_count;
	logic        accel_sensor_on;
	logic        gyro_sample_tick;
	logic        accel_sample_tick;
	int          num_errors;
	int          samples_checked;
	int          gap;
	int          off_cycles;
	logic [7:0]  map_addr [7];
	logic [7:0]  map_mask [7];

	motion_sensor_filter_config u_dut (
		.core_clk           (core_clk),
		.rstn               (rstn),
		.reg_wr             (reg_wr),
		.reg_rd             (reg_rd),
		.reg_addr           (reg_addr),
		.reg_wdata          (reg_wdata),
		.reg_rdata          (reg_rdata),
		.accel_lp_mode      (accel_lp_mode),
		.gyro_selftest      (gyro_selftest),
		.accel_selftest     (accel_selftest),
		.gyro_range_select  (gyro_range_select),
		.accel_range_select (accel_range_select),
		.gyro_filter_on     (gyro_filter_on),
		.gyro_rate_khz      (gyro_rate_khz),
		.accel_bw_x10       (accel_bw_x10),
		.accel_rate_khz     (accel_rate_khz),
		.accel_avg_count    (accel_avg_count),
		.gyro_avg_count     (gyro_avg_count),
		.accel_sensor_on    (accel_sensor_on),
		.gyro_sample_tick   (gyro_sample_tick),
		.accel_sample_tick  (accel_sample_tick)
	);

	// 10 MHz core clock
	always #50 core_clk = ~core_clk;

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// case equality so an unknown output never counts as a match
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// one-cycle write strobe, taken at the following edge
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= addr;
		reg_wdata <= data;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
		// let the stored value settle before a caller looks at it
		#1;
	endtask

	// read data is combinational, looked at 10 ns after the edge
	task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= addr;
		#10;
		chk({8'h00, reg_rdata}, {8'h00, exp}, "read data");
		@(posedge core_clk);
		reg_rd   <= 1'b0;
	endtask

	// bounded wait for the next sample pulse; n is the cycles spent waiting
	task automatic wait_tick(input logic accel, output int n);
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
			if (n > 12000) begin
				num_errors++;
				$display("mismatch at %0t: no sample pulse", $time);
				report_and_stop();
			end
		end while ((accel ? accel_sample_tick : gyro_sample_tick) !== 1'b1);
	endtask

	// shadows load after any sample pulse, so either rate serves; one more edge to land
	task automatic settle(input logic accel);
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
			if (n > 12000) begin
				num_errors++;
				$display("mismatch at %0t: no %s pulse", $time, accel ? "accel" : "gyro");
				report_and_stop();
			end
		end while (gyro_sample_tick !== 1'b1 && accel_sample_tick !== 1'b1);
		@(posedge core_clk);
		#1;
	endtask

	// first gap after a change may be partial, so skip two gaps before measuring the third
	task automatic measure(input int exp);
		wait_tick(1'b0, gap);
		wait_tick(1'b0, gap);
		wait_tick(1'b0, gap);
		chk(gap[15:0], exp[15:0], "gyro pulse spacing");
	endtask

	initial begin
		core_clk      = 1'b0;
		rstn          = 1'b0;
		reg_wr        = 1'b0;
		reg_rd        = 1'b0;
		reg_addr      = 8'h00;
		reg_wdata     = 8'h00;
		accel_lp_mode = 1'b0;
		num_errors    = 0;
		samples_checked = 0;
		map_addr = '{8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h40};
		map_mask = '{8'hFF, sensor_cfg_pkg::MASK_GYRO_LPF, sensor_cfg_pkg::MASK_GYRO_CFG,
			sensor_cfg_pkg::MASK_ACCEL_CFG, sensor_cfg_pkg::MASK_ACCEL_CFG2,
			sensor_cfg_pkg::MASK_LP_GYRO_CFG, 8'h00};
		repeat (12) @(posedge core_clk);
		rstn <= 1'b1;
		// reset state of registers and derived outputs
		for (int i = 0; i < 6; i++) begin
			rd(map_addr[i], sensor_cfg_pkg::RST_CFG);
		end
		chk({13'h0, gyro_selftest}, 16'h0000, "gyro self-test");
		chk({12'h0, gyro_rate_khz}, 16'h0008, "gyro rate reset");
		chk({13'h0, accel_rate_khz}, 16'h0001, "accel rate reset");
		chk(accel_bw_x10, sensor_cfg_pkg::BW_A_218, "accel bw reset");
		chk({8'h00, gyro_avg_count}, 16'h0001, "gyro avg reset");
		chk({15'h0, accel_sensor_on}, 16'h0001, "accel on");
		measure(sensor_cfg_pkg::BASE_CYCLES * 4);
		// reserved bits read zero; unmapped place keeps nothing
		for (int i = 0; i < 7; i++) begin
			wr(map_addr[i], 8'hFF);
			rd(map_addr[i], map_mask[i]);
			wr(map_addr[i], 8'h00);
		end
		// self-test triggers: all gyro axes, gyro Y alone, then accel X and Z together
		wr(8'h1B, 8'hE0);
		chk({13'h0, gyro_selftest}, 16'h0007, "gyro self-test all");
		wr(8'h1B, 8'h40);
		chk({13'h0, gyro_selftest}, 16'h0002, "gyro self-test y");
		wr(8'h1C, 8'hA0);
		chk({13'h0, accel_selftest}, 16'h0005, "accel self-test x z");
		// accel range acts at once, gyro range through the shadow
		for (int r = 0; r < 4; r++) begin
			wr(8'h1C, 8'(r << 3));
			chk({14'h0, accel_range_select}, 16'(r), "accel range");
		end
		for (int r = 0; r < 4; r++) begin
			wr(8'h1B, 8'((r << 3) | 1));
			settle(1'b0);
			chk({14'h0, gyro_range_select}, 16'(r), "gyro range");
			chk({12'h0, gyro_rate_khz}, 16'h0000, "gyro bypass rate");
			chk({15'h0, gyro_filter_on}, 16'h0000, "gyro filter off");
		end
		// divider at the 32 kHz rate
		measure(sensor_cfg_pkg::BASE_CYCLES);
		wr(8'h19, 8'h03);
		measure(sensor_cfg_pkg::BASE_CYCLES * 4);
		wr(8'h19, 8'h00);
		// bypass pattern 10, then lowpass settings 3 and 7
		wr(8'h1B, 8'h02);
		settle(1'b0);
		chk({12'h0, gyro_rate_khz}, 16'h0000, "gyro pattern 10");
		wr(8'h1B, 8'h00);
		wr(8'h1A, 8'h03);
		settle(1'b0);
		chk({12'h0, gyro_rate_khz}, 16'h0001, "gyro setting 3");
		chk({15'h0, gyro_filter_on}, 16'h0001, "gyro filter on");
		wr(8'h1A, 8'h07);
		settle(1'b0);
		chk({12'h0, gyro_rate_khz}, 16'h0008, "gyro setting 7");
		// low-power gyro overrides the 8 kHz lowpass choice
		wr(8'h1E, 8'hF0);
		settle(1'b0);
		chk({12'h0, gyro_rate_khz}, 16'h0001, "gyro low-power rate");
		chk({8'h00, gyro_avg_count}, 16'h0080, "gyro avg 128");
		wr(8'h1E, 8'hB0);
		settle(1'b0);
		chk({8'h00, gyro_avg_count}, 16'h0008, "gyro avg 8");
		wr(8'h1E, 8'h00);
		// accel bypass, then settings 1 and 7
		wr(8'h1D, 8'h08);
		settle(1'b1);
		chk({13'h0, accel_rate_khz}, 16'h0004, "accel bypass rate");
		chk(accel_bw_x10, sensor_cfg_pkg::BW_A_BYPASS, "accel bypass bw");
		chk({8'h00, accel_avg_count}, 16'h0001, "accel no averaging");
		wr(8'h1D, 8'h01);
		settle(1'b1);
		chk(accel_bw_x10, sensor_cfg_pkg::BW_A_218, "accel setting 1");
		chk({13'h0, accel_rate_khz}, 16'h0001, "accel rate 1k");
		wr(8'h1D, 8'h07);
		settle(1'b1);
		chk(accel_bw_x10, sensor_cfg_pkg::BW_A_420, "accel setting 7");
		// low-power accel: 4-sample averaging, duty cycling seen on the pin, then deepest averaging
		// divider 4 leaves room for a 4-sample window to end before the next period
		@(posedge core_clk);
		accel_lp_mode <= 1'b1;
		wr(8'h19, 8'h04);
		wr(8'h1D, 8'h07);
		settle(1'b1);
		chk({8'h00, accel_avg_count}, 16'h0004, "accel avg 4");
		off_cycles = 0;
		while (accel_sensor_on !== 1'b0 && off_cycles < 90000) begin
			@(posedge core_clk);
			#1;
			off_cycles++;
		end
		chk({15'h0, accel_sensor_on === 1'b0}, 16'h0001, "accel duty cycle");
		wr(8'h1D, 8'h37);
		settle(1'b1);
		chk({8'h00, accel_avg_count}, 16'h0020, "accel avg 32");
		report_and_stop();
	end
endmodule
